// >>> rtl/frb_params.svh
// Register indices, field positions and reset values of the frame-reference bank
`ifndef FRB_PARAMS_SVH
`define FRB_PARAMS_SVH

// Word index = byte address / 4
`define FRB_ADR_IDX_MSB    8
`define FRB_ADR_IDX_LSB    2
`define FRB_IDX_SYNC_LO    7'h46
`define FRB_IDX_CTRL       7'h47
`define FRB_IDX_DIV        7'h48
`define FRB_IDX_DLYA       7'h49
`define FRB_IDX_DLYB       7'h4a
`define FRB_IDX_OUTPUT_CHANNEL_DIVIDE      7'h4b
`define FRB_IDX_FIXED      7'h4c
`define FRB_IDX_STATUS     7'h60

`define FRB_RST_SYNC_LO    16'hc350
`define FRB_RST_CTRL       16'h0080
`define FRB_RST_DIV        16'h0001
`define FRB_RST_DLYA       16'h003f
`define FRB_RST_DLYB       16'h0000
`define FRB_RST_OUTPUT_CHANNEL_DIVIDE      16'h0800
`define FRB_RST_FIXED      16'h000c

`define FRB_CTRL_PREDIV_MSB 7
`define FRB_CTRL_PREDIV_LSB 5
`define FRB_CTRL_MULTI     4
`define FRB_CTRL_EN        3
`define FRB_CTRL_REPEAT    2
`define FRB_DIV_MSB        10
`define FRB_DLY_LO_MSB     5
`define FRB_DLY_HI_LSB     6
`define FRB_DLY_HI_MSB     11
`define FRB_PCNT_LSB       12
`define FRB_PCNT_MSB       15
`define FRB_OUTPUT_CHANNEL_DIVIDE_LSB      6
`define FRB_OUTPUT_CHANNEL_DIVIDE_MSB      10

`define FRB_PREDIV_BY2     3'h2
`define FRB_PREDIV_BY4     3'h4
`define FRB_DLY_TAPS       64

`endif

// >>> rtl/frb_pkg.sv
// Types and shared decode functions of the frame-reference bank
package frb_pkg;

    typedef enum logic [1:0] {
        FRB_BUS_IDLE = 2'b01,
        FRB_BUS_ACK  = 2'b10
    } frb_bus_state_t;

    typedef enum logic [3:0] {
        FRB_GEN_OFF   = 4'b0001,
        FRB_GEN_CONT  = 4'b0010,
        FRB_GEN_BURST = 4'b0100,
        FRB_GEN_REPT  = 4'b1000
    } frb_gen_state_t;

    // Channel divide ratio, zero for an unused code
    function automatic logic [8:0] output_channel_divide_ratio(input logic [4:0] code);
        case (code)
            5'h00:   output_channel_divide_ratio = 9'h002;
            5'h01:   output_channel_divide_ratio = 9'h004;
            5'h03:   output_channel_divide_ratio = 9'h008;
            5'h05:   output_channel_divide_ratio = 9'h010;
            5'h07:   output_channel_divide_ratio = 9'h020;
            5'h09:   output_channel_divide_ratio = 9'h040;
            5'h0c:   output_channel_divide_ratio = 9'h080;
            5'h0e:   output_channel_divide_ratio = 9'h100;
            default: output_channel_divide_ratio = 9'h000;
        endcase
    endfunction

    // Pre-divide ratio, zero for an invalid code
    function automatic logic [2:0] prediv_ratio(input logic [2:0] code);
        if (code == 3'h2) begin
            prediv_ratio = 3'h2;
        end else if (code == 3'h4) begin
            prediv_ratio = 3'h4;
        end else begin
            prediv_ratio = 3'h0;
        end
    endfunction

endpackage

// >>> rtl/frb_cfg_if.sv
// Configuration and status bundle between register bank and pulse generator
`timescale 1ns/10ps
interface frb_cfg_if;
    logic        en;
    logic        repeat_mode;
    logic        multi;
    logic [2:0]  prediv;
    logic [10:0] divval;
    logic [4:0]  output_channel_divide;
    logic [3:0]  pcnt;
    logic        req_rise;
    logic        pulse;
    logic        busy;
    logic [3:0]  burst_left;

    modport ctrl (output en, repeat_mode, multi, prediv, divval, output_channel_divide, pcnt, req_rise,
                  input  pulse, busy, burst_left);
    modport gen  (input  en, repeat_mode, multi, prediv, divval, output_channel_divide, pcnt, req_rise,
                  output pulse, busy, burst_left);
endinterface

// >>> rtl/frb_pulse_gen.sv
// Frame-reference pulse generator: divider chain, burst counter, repeater
`timescale 1ns/10ps
module frb_pulse_gen (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Configuration
    frb_cfg_if.gen    cfg
);
    logic [8:0]            ch_ratio;
    logic [2:0]            pre_ratio;
    logic [10:0]           fr_lim;
    logic [8:0]            ch_cnt_r;
    logic [2:0]            pre_cnt_r;
    logic [10:0]           fr_cnt_r;
    logic                  tick_ch;
    logic                  tick_pre;
    logic                  tick_fr;
    logic [3:0]            burst_r;
    frb_pkg::frb_gen_state_t state_r;
    frb_pkg::frb_gen_state_t state_nxt;

    assign ch_ratio  = frb_pkg::output_channel_divide_ratio(cfg.output_channel_divide);
    assign pre_ratio = frb_pkg::prediv_ratio(cfg.prediv);
    // A zero divide value would stall the chain, so it acts as one
    assign fr_lim    = (cfg.divval == 11'h000) ? 11'h001 : cfg.divval;
    assign tick_ch   = (ch_ratio != 9'h000) && (ch_cnt_r == ch_ratio - 9'h001);
    assign tick_pre  = tick_ch && (pre_ratio != 3'h0) && (pre_cnt_r == pre_ratio - 3'h1);
    assign tick_fr   = tick_pre && (fr_cnt_r == fr_lim - 11'h001);

    always_comb begin
        if (!cfg.en) begin
            state_nxt = frb_pkg::FRB_GEN_OFF;
        end else if (cfg.repeat_mode) begin
            state_nxt = frb_pkg::FRB_GEN_REPT;
        end else if (cfg.multi) begin
            state_nxt = frb_pkg::FRB_GEN_BURST;
        end else begin
            state_nxt = frb_pkg::FRB_GEN_CONT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= frb_pkg::FRB_GEN_OFF;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // Divider chain restarts whenever generation is off
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && !cfg.en)) begin
            ch_cnt_r  <= 9'h000;
            pre_cnt_r <= 3'h0;
            fr_cnt_r  <= 11'h000;
        end else if (ce_i) begin
            ch_cnt_r <= tick_ch ? 9'h000 : ch_cnt_r + 9'h001;
            if (tick_pre) begin
                pre_cnt_r <= 3'h0;
            end else if (tick_ch) begin
                pre_cnt_r <= pre_cnt_r + 3'h1;
            end
            if (tick_fr) begin
                fr_cnt_r <= 11'h000;
            end else if (tick_pre) begin
                fr_cnt_r <= fr_cnt_r + 11'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg.pulse <= 1'b0;
            burst_r   <= 4'h0;
        end else if (ce_i) begin
            case (state_r)
                frb_pkg::FRB_GEN_CONT: begin
                    cfg.pulse <= tick_fr;
                    burst_r   <= 4'h0;
                end
                frb_pkg::FRB_GEN_BURST: begin
                    cfg.pulse <= tick_fr && (burst_r != 4'h0);
                    // A new request reloads the count, even mid-burst
                    if (cfg.req_rise) begin
                        burst_r <= cfg.pcnt;
                    end else if (tick_fr && (burst_r != 4'h0)) begin
                        burst_r <= burst_r - 4'h1;
                    end
                end
                frb_pkg::FRB_GEN_REPT: begin
                    cfg.pulse <= cfg.req_rise;
                    burst_r   <= 4'h0;
                end
                default: begin
                    cfg.pulse <= 1'b0;
                    burst_r   <= 4'h0;
                end
            endcase
        end
    end

    assign cfg.busy       = (burst_r != 4'h0);
    assign cfg.burst_left = burst_r;

endmodule // frb_pulse_gen

// >>> rtl/frb_regs_top.sv
// Frame-reference and channel-divider register bank with Wishbone slave
`timescale 1ns/10ps
`include "frb_params.svh"

module frb_regs_top (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [8:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Request pin, asynchronous
    input  wire logic        frame_ref_request_pin_i,
    // Frame-reference outputs, one per delay field
    output logic      [3:0]  frame_ref_o,
    // Configuration seen by the rest of the synthesizer
    output logic      [15:0] phase_sync_delay_count_lo_o,
    output logic      [8:0]  chan_div_ratio_o
);

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // One-hot word select shared by the write and read decodes; bit 7 is the status word
    function automatic logic [7:0] word_select(input logic [6:0] i);
        if (i == `FRB_IDX_SYNC_LO) begin
            word_select = 8'h01;
        end else if (i == `FRB_IDX_CTRL) begin
            word_select = 8'h02;
        end else if (i == `FRB_IDX_DIV) begin
            word_select = 8'h04;
        end else if (i == `FRB_IDX_DLYA) begin
            word_select = 8'h08;
        end else if (i == `FRB_IDX_DLYB) begin
            word_select = 8'h10;
        end else if (i == `FRB_IDX_OUTPUT_CHANNEL_DIVIDE) begin
            word_select = 8'h20;
        end else if (i == `FRB_IDX_FIXED) begin
            word_select = 8'h40;
        end else if (i == `FRB_IDX_STATUS) begin
            word_select = 8'h80;
        end else begin
            word_select = 8'h00;
        end
    endfunction

    // Register storage
    logic [15:0] sync_lo_r;
    logic [15:0] ctrl_r;
    logic [15:0] div_r;
    logic [15:0] dlya_r;
    logic [15:0] dlyb_r;
    logic [15:0] output_channel_divide_r;
    logic [15:0] fixed_r;

    // Bus slave
    frb_pkg::frb_bus_state_t bus_r;
    logic [6:0]  idx;
    logic        req;
    logic        wr_go;
    logic        hit;
    logic [15:0] rd_val;
    logic [15:0] status_w;
    logic [7:0]  wsel;
    logic [7:0]  rsel;
    logic        we_sync_lo;
    logic        we_ctrl;
    logic        we_div;
    logic        we_dlya;
    logic        we_dlyb;
    logic        we_output_channel_divide;
    logic        we_fixed;

    // Request pin synchroniser
    logic        req_meta_r;
    logic        req_sync_r;
    logic        req_prev_r;

    // Delay line
    logic [`FRB_DLY_TAPS-1:0] dly_line_r;
    logic [5:0]  dly_sel [4];
    logic        cfg_bad;

    frb_cfg_if cfg ();

    assign idx   = wb_adr_i[`FRB_ADR_IDX_MSB:`FRB_ADR_IDX_LSB];
    assign req   = wb_cyc_i && wb_stb_i && (bus_r == frb_pkg::FRB_BUS_IDLE);
    assign wr_go = req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_r    <= frb_pkg::FRB_BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            case (bus_r)
                frb_pkg::FRB_BUS_IDLE: begin
                    if (req) begin
                        bus_r    <= frb_pkg::FRB_BUS_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                frb_pkg::FRB_BUS_ACK: begin
                    bus_r    <= frb_pkg::FRB_BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
                default: begin
                    bus_r    <= frb_pkg::FRB_BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // Write decode; the status word and unmapped words ignore writes
    always_comb begin
        wsel       = word_select(idx);
        we_sync_lo = 1'b0;
        we_ctrl    = 1'b0;
        we_div     = 1'b0;
        we_dlya    = 1'b0;
        we_dlyb    = 1'b0;
        we_output_channel_divide   = 1'b0;
        we_fixed   = 1'b0;
        if (wr_go) begin
            we_sync_lo = wsel[0];
            we_ctrl    = wsel[1];
            we_div     = wsel[2];
            we_dlya    = wsel[3];
            we_dlyb    = wsel[4];
            we_output_channel_divide   = wsel[5];
            we_fixed   = wsel[6];
        end
    end

    // Read decode; unmapped words and the upper half read as zero
    always_comb begin
        rsel   = word_select(idx);
        hit    = (rsel != 8'h00);
        rd_val = 16'h0000;
        if (rsel[0]) begin
            rd_val = sync_lo_r;
        end else if (rsel[1]) begin
            rd_val = ctrl_r;
        end else if (rsel[2]) begin
            rd_val = div_r;
        end else if (rsel[3]) begin
            rd_val = dlya_r;
        end else if (rsel[4]) begin
            rd_val = dlyb_r;
        end else if (rsel[5]) begin
            rd_val = output_channel_divide_r;
        end else if (rsel[6]) begin
            rd_val = fixed_r;
        end else if (rsel[7]) begin
            rd_val = status_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (req && !wb_we_i && hit) begin
                wb_dat_o <= {16'h0000, rd_val};
            end else if (req) begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Register storage, each word keeps its value until written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_lo_r <= `FRB_RST_SYNC_LO;
        end else if (ce_i && we_sync_lo) begin
            sync_lo_r <= wr16(sync_lo_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `FRB_RST_CTRL;
        end else if (ce_i && we_ctrl) begin
            ctrl_r <= wr16(ctrl_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= `FRB_RST_DIV;
        end else if (ce_i && we_div) begin
            div_r <= wr16(div_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlya_r <= `FRB_RST_DLYA;
        end else if (ce_i && we_dlya) begin
            dlya_r <= wr16(dlya_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlyb_r <= `FRB_RST_DLYB;
        end else if (ce_i && we_dlyb) begin
            dlyb_r <= wr16(dlyb_r, wb_dat_i, wb_sel_i);
        end
    end

    // Divide and fixed words are stored as written; the logic uses only the divide code in bits 10:6
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_channel_divide_r <= `FRB_RST_OUTPUT_CHANNEL_DIVIDE;
        end else if (ce_i && we_output_channel_divide) begin
            output_channel_divide_r <= wr16(output_channel_divide_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fixed_r <= `FRB_RST_FIXED;
        end else if (ce_i && we_fixed) begin
            fixed_r <= wr16(fixed_r, wb_dat_i, wb_sel_i);
        end
    end

    // Request pin: two flops before any logic looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
        end else if (ce_i) begin
            req_meta_r <= frame_ref_request_pin_i;
            req_sync_r <= req_meta_r;
        end
    end

    // Edge detector starts at the pin's idle level, so reset gives no false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_prev_r <= 1'b0;
        end else if (ce_i) begin
            req_prev_r <= req_sync_r;
        end
    end

    assign cfg.en          = ctrl_r[`FRB_CTRL_EN];
    assign cfg.repeat_mode = ctrl_r[`FRB_CTRL_REPEAT];
    assign cfg.multi       = ctrl_r[`FRB_CTRL_MULTI];
    assign cfg.prediv      = ctrl_r[`FRB_CTRL_PREDIV_MSB:`FRB_CTRL_PREDIV_LSB];
    assign cfg.divval      = div_r[`FRB_DIV_MSB:0];
    assign cfg.output_channel_divide       = output_channel_divide_r[`FRB_OUTPUT_CHANNEL_DIVIDE_MSB:`FRB_OUTPUT_CHANNEL_DIVIDE_LSB];
    assign cfg.pcnt        = dlyb_r[`FRB_PCNT_MSB:`FRB_PCNT_LSB];
    assign cfg.req_rise    = req_sync_r && !req_prev_r;

    frb_pulse_gen u_gen (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .cfg   (cfg.gen)
    );

    assign cfg_bad = (frb_pkg::output_channel_divide_ratio(cfg.output_channel_divide) == 9'h000) ||
                     (frb_pkg::prediv_ratio(cfg.prediv) == 3'h0);
    assign status_w = {8'h00, cfg.burst_left, 1'b0, cfg_bad, req_sync_r, cfg.busy};

    // Delay taps; the line costs flops but keeps each output independent
    assign dly_sel[0] = dlya_r[`FRB_DLY_LO_MSB:0];
    assign dly_sel[1] = dlya_r[`FRB_DLY_HI_MSB:`FRB_DLY_HI_LSB];
    assign dly_sel[2] = dlyb_r[`FRB_DLY_LO_MSB:0];
    assign dly_sel[3] = dlyb_r[`FRB_DLY_HI_MSB:`FRB_DLY_HI_LSB];

    // Pulses still in flight are dropped as soon as generation is switched off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_line_r <= '0;
        end else if (ce_i) begin
            if (!cfg.en) begin
                dly_line_r <= '0;
            end else begin
                dly_line_r <= {dly_line_r[`FRB_DLY_TAPS-2:0], cfg.pulse};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_ref_o <= 4'h0;
        end else if (ce_i) begin
            for (int k = 0; k < 4; k++) begin
                frame_ref_o[k] <= dly_line_r[dly_sel[k]];
            end
        end
    end

    // Low half only; the upper half lives in a neighbouring register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_sync_delay_count_lo_o <= `FRB_RST_SYNC_LO;
        end else if (ce_i) begin
            phase_sync_delay_count_lo_o <= sync_lo_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_div_ratio_o <= 9'h000;
        end else if (ce_i) begin
            chan_div_ratio_o <= frb_pkg::output_channel_divide_ratio(cfg.output_channel_divide);
        end
    end

endmodule // frb_regs_top

// >>> bench/frb_regs_sva.sv
// Bus and output checks for the frame-reference register bank
`timescale 1ns/10ps
module frb_regs_sva (
    // Clock, reset, enable
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [8:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Outputs
    input wire logic [3:0]  frame_ref_o,
    input wire logic [15:0] phase_sync_delay_count_lo_o,
    input wire logic [8:0]  chan_div_ratio_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       en_r;
    logic [6:0] quiet_r;
    // Enable copy tracked from bus writes; the quiet counter leaves room for the longest delay tap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[8:2] == 7'h47) begin
            en_r <= wb_dat_i[3];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || en_r) begin
            quiet_r <= 7'h00;
        end else if (quiet_r != 7'h7f) begin
            quiet_r <= quiet_r + 7'h01;
        end
    end
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_upper_zero; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper half set");
    property p_sync_rst; disable iff (1'b0) rst_i ##1 rst_i |=> phase_sync_delay_count_lo_o == 16'hc350; endproperty
    a_sync_rst: assert property (p_sync_rst) else $error("sync count low not c350");
    property p_ratio_rst; disable iff (1'b0) $fell(rst_i) |=> chan_div_ratio_o == 9'h002; endproperty
    a_ratio_rst: assert property (p_ratio_rst) else $error("divide ratio not 2 after reset");
    property p_ratio_legal; chan_div_ratio_o == 9'h000 || ($onehot(chan_div_ratio_o) && !chan_div_ratio_o[0]); endproperty
    a_ratio_legal: assert property (p_ratio_legal) else $error("illegal divide ratio");
    property p_off_quiet; quiet_r == 7'h7f |-> frame_ref_o == 4'h0; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("pulse while disabled");
    property p_pulse_one; $rose(frame_ref_o[0]) |=> !frame_ref_o[0]; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one cycle");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_pulse: cover property ($rose(frame_ref_o[0]));
    c_quiet: cover property (quiet_r == 7'h7f);
endmodule // frb_regs_sva

bind frb_regs_top frb_regs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frame_ref_o(frame_ref_o), .phase_sync_delay_count_lo_o(phase_sync_delay_count_lo_o),
    .chan_div_ratio_o(chan_div_ratio_o));

// >>> bench/test_sysref_output_channel_divide_config_regs.sv
// Self-checking testbench of the frame-reference register bank
`timescale 1ns/10ps
module test_sysref_output_channel_divide_config_regs;
    logic clk, rst, cyc, stb, we, pin, ce;
    logic [8:0]  adr;
    logic [31:0] wd, rdat;
    logic [3:0]  sel, fro;
    logic        ack;
    logic [15:0] sync_lo, q;
    logic [8:0]  ratio;
    int failures, total_checks, n, c;
    // Row: index, write data, lanes, expected read back
    localparam logic [42:0] ROWS [10] = '{
        {7'h46, 16'h1234, 4'h3, 16'h1234}, {7'h47, 16'h00e5, 4'h3, 16'h00e5},
        {7'h48, 16'h07ff, 4'h3, 16'h07ff}, {7'h49, 16'h0fff, 4'h3, 16'h0fff},
        {7'h4a, 16'hf555, 4'h3, 16'hf555}, {7'h4a, 16'hffff, 4'h1, 16'hf5ff},
        {7'h4a, 16'h0000, 4'h2, 16'h00ff}, {7'h4b, 16'h0b80, 4'h3, 16'h0b80},
        {7'h4c, 16'h000c, 4'h3, 16'h000c}, {7'h50, 16'hffff, 4'h3, 16'h0000}};
    localparam logic [15:0] RST_VAL [7] = '{16'hc350, 16'h0080, 16'h0001, 16'h003f,
                                            16'h0000, 16'h0800, 16'h000c};
    frb_regs_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .frame_ref_request_pin_i(pin), .frame_ref_o(fro),
        .phase_sync_delay_count_lo_o(sync_lo), .chan_div_ratio_o(ratio));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [6:0] idx, input logic [15:0] d,
                       input logic [3:0] s, output logic [15:0] r);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wd <= {16'h0, d}; sel <= s;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        r = rdat[15:0];
        if (k >= 50) failures++;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d, 4'h3, q);
    endtask
    // Cycles until output bit k is next seen high
    task automatic wait_hi(input int k, output int m);
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (fro[k] !== 1'b1 && m < 300);
    endtask
    task automatic count(input int len, output int p);
        p = 0;
        repeat (len) begin
            @(negedge clk);
            if (fro[0] === 1'b1) p++;
        end
    endtask
    task automatic request;
        @(posedge clk);
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        pin <= 1'b0;
    endtask
    function automatic logic [8:0] exp_ratio(input int code);
        case (code)
            0: return 9'h002;   1: return 9'h004;   3: return 9'h008;   5: return 9'h010;
            7: return 9'h020;   9: return 9'h040;   12: return 9'h080;  14: return 9'h100;
            default: return 9'h000;
        endcase
    endfunction
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run is about 1200 cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_of_test;
    end
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wd = '0; sel = '0; pin = 1'b0;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i][42:36], ROWS[i][35:20], ROWS[i][19:16], q);
            bus(1'b0, ROWS[i][42:36], 16'h0, 4'h3, q);
            check("readback", q, ROWS[i][15:0]);
        end
        check("sync low out", sync_lo, 16'h1234);
        $display("test rows done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 7'h46 + i[6:0], 16'h0, 4'h3, q);
            check("reset value", q, RST_VAL[i]);
        end
        check("sync low reset", sync_lo, 16'hc350);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            wr(7'h4b, 16'h0800 | 16'(i << 6));
            repeat (3) @(posedge clk);
            check("channel ratio", ratio, exp_ratio(i));
        end
        $display("test channel divide done");
        wr(7'h4b, 16'h0800);
        wr(7'h48, 16'h0003);
        wr(7'h49, 16'h0140);
        wr(7'h4a, 16'h0102);
        for (int p = 2; p <= 4; p += 2) begin
            wr(7'h47, 16'(p << 5) | 16'h0009);
            repeat (2) wait_hi(0, n);
            wait_hi(0, n);
            check("master period", n, 6 * p);
            wait_hi(1, n);
            check("delay taps", n, 5);
        end
        wait_hi(0, n);
        wait_hi(2, n);
        check("delay tap three", n, 2);
        wait_hi(3, n);
        check("delay tap four", n, 2);
        wr(7'h47, 16'h0069);
        count(30, c);
        count(100, c);
        check("invalid prediv", c, 0);
        bus(1'b0, 7'h60, 16'h0, 4'h3, q);
        check("status invalid", q, 16'h0004);
        $display("test master done");
        wr(7'h47, 16'h004d);
        count(30, c);
        count(60, c);
        check("repeater idle", c, 0);
        request;
        count(60, c);
        check("repeater pulse", c, 1);
        wr(7'h4a, 16'h3000);
        wr(7'h47, 16'h0059);
        count(30, c);
        count(60, c);
        check("burst idle", c, 0);
        request;
        count(100, c);
        check("burst pulses", c, 3);
        $display("test request done");
        wr(7'h47, 16'h0049);
        wait_hi(0, n);
        @(posedge clk);
        ce <= 1'b0;
        count(40, c);
        check("frozen", c, 0);
        @(posedge clk);
        ce <= 1'b1;
        wait_hi(0, n);
        wait_hi(0, n);
        check("resumed period", n, 12);
        wr(7'h47, 16'h0041);
        count(80, c);
        count(100, c);
        check("disabled", c, 0);
        $display("test disable done");
        end_of_test;
    end
endmodule // test_sysref_output_channel_divide_config_regs
